//--- lpt_gpio.sv
// parallel connector gpio block: avalon register slave and eight port lanes
//
// Function
// - each port has eight data, four control and five status lines
// - data output gives twelve outputs, five inputs; data input gives four and thirteen
// - open-drain control mode gives eight outputs and nine inputs
// - direction chosen once at configuration, locked while the port is active
// - an unconfigured direction means the data group is output
// - up to eight independent ports, numbered from zero
// - a target value below sixteen is a port index, not an address
// - control lines are push-pull outputs except in open-drain mode, following their drive bits
// - status lines always inputs; data lines inputs only in input mode
// - open-drain mode also samples the four control lines
// - each input gives a true level and a complementary level
// - per-output invert: set makes an asserted value drive low
// - auto-return enable exists for output lines only
// - sample captures one or all ports into true and complementary levels
// - update moves drive values of one or all ports onto the pins
`timescale 1ns/1ps
`include "lpt_gpio_map.svh"

module lpt_gpio
   import lpt_gpio_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic [`ADDR_W-1:0]    avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  in_pins_type [`NUM_PORTS-1:0] pins_in,
   output out_pins_type [`NUM_PORTS-1:0] pins_out,
   output out_pins_type [`NUM_PORTS-1:0] pins_oe_n
);

   // ==========================================
   // declarations
   logic                 rst_meta_reg;
   logic                 rst_sync_n;

   port_mode_type        mode_reg    [`NUM_PORTS];
   logic [`NUM_PORTS-1:0] active_reg;
   logic [15:0]          base_reg    [`NUM_PORTS];
   out_pins_type         drive_reg   [`NUM_PORTS];
   out_pins_type         invert_reg  [`NUM_PORTS];
   out_pins_type         autoret_reg [`NUM_PORTS];
   logic [31:0]          rettime_reg [`NUM_PORTS];

   logic [`NUM_PORTS-1:0] sample_reg;
   logic [`NUM_PORTS-1:0] update_reg;
   logic [`NUM_PORTS-1:0] return_reg;
   logic [`NUM_PORTS-1:0] pending;
   in_pins_type          level_true  [`NUM_PORTS];
   in_pins_type          level_not   [`NUM_PORTS];

   logic [3:0]           win;
   logic [3:0]           win_ofs;
   logic [2:0]           idx;
   logic [2:0]           word;
   logic                 is_port;
   logic                 is_cmd;
   logic                 wr_go;
   logic [31:0]          wmask;
   logic [31:0]          rdata_next;
   logic [15:0]          target;
   cmd_op_type           cmd_op;
   logic [`NUM_PORTS-1:0] hit;

   // ==========================================
   // reset release
   // assertion stays asynchronous; release passes two stages
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // ==========================================
   // address decode
   assign win     = avs_address[8:5];
   assign win_ofs = win - `PORT_WIN_FIRST;
   assign idx     = win_ofs[2:0];
   assign word    = avs_address[4:2];
   assign is_port = (win >= `PORT_WIN_FIRST) && (win <= `PORT_WIN_LAST);
   assign is_cmd  = (avs_address == `REG_CMD);
   assign wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // a write lands on the edge where the master sees waitrequest low
   assign wr_go   = ce && avs_write && !avs_waitrequest;

   function automatic logic [31:0] merge(input logic [31:0] old_val,
                                         input logic [31:0] new_val,
                                         input logic [31:0] mask);
      merge = (old_val & ~mask) | (new_val & mask);
   endfunction

   // ==========================================
   // bus handshake
   // one wait cycle per access; readdata is registered alongside
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (ce) begin
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rdata_next : 32'h0000_0000;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // ==========================================
   // read mux
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (avs_address == `REG_STATUS) begin
         rdata_next = {16'h0000, active_reg, pending};
      end else if (is_port) begin
         case (word)
            `OFS_CFG: begin
               rdata_next = {29'h0, active_reg[idx], 2'(mode_reg[idx])};
            end
            `OFS_BASE: begin
               rdata_next = {16'h0000, base_reg[idx]};
            end
            `OFS_DRIVE: begin
               rdata_next = {20'h0, drive_reg[idx]};
            end
            `OFS_INVERT: begin
               rdata_next = {20'h0, invert_reg[idx]};
            end
            `OFS_AUTORET: begin
               rdata_next = {20'h0, autoret_reg[idx]};
            end
            `OFS_RETTIME: begin
               rdata_next = rettime_reg[idx];
            end
            `OFS_IN_TRUE: begin
               rdata_next = {15'h0, level_true[idx]};
            end
            `OFS_IN_NOT: begin
               rdata_next = {15'h0, level_not[idx]};
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // ==========================================
   // port configuration
   // direction writes after activation are dropped, so a live port cannot flip
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         active_reg <= '0;
         for (int p = 0; p < `NUM_PORTS; p++) begin
            mode_reg[p] <= mode_unset;
            base_reg[p] <= `RST_BASE;
         end
      end else if (wr_go && is_port) begin
         if (word == `OFS_CFG && !active_reg[idx] && avs_byteenable[0]) begin
            mode_reg[idx]   <= port_mode_type'(avs_writedata[`CFG_MODE_LSB +: 2]);
            active_reg[idx] <= avs_writedata[`CFG_ACTIVE_BIT];
         end
         if (word == `OFS_BASE) begin
            base_reg[idx] <= 16'(merge({16'h0, base_reg[idx]}, avs_writedata, wmask));
         end
      end
   end

   // ==========================================
   // drive values and output options
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int p = 0; p < `NUM_PORTS; p++) begin
            drive_reg[p]   <= `RST_PINS;
            invert_reg[p]  <= `RST_PINS;
            autoret_reg[p] <= `RST_PINS;
            rettime_reg[p] <= `RST_RETTIME;
         end
      end else if (wr_go && is_port) begin
         case (word)
            `OFS_DRIVE: begin
               drive_reg[idx] <= 12'(merge({20'h0, drive_reg[idx]}, avs_writedata, wmask));
            end
            `OFS_INVERT: begin
               invert_reg[idx] <= 12'(merge({20'h0, invert_reg[idx]}, avs_writedata,
                                            wmask));
            end
            `OFS_AUTORET: begin
               autoret_reg[idx] <= 12'(merge({20'h0, autoret_reg[idx]}, avs_writedata,
                                             wmask));
            end
            `OFS_RETTIME: begin
               rettime_reg[idx] <= merge(rettime_reg[idx], avs_writedata, wmask);
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // command targeting
   // only installed (active) ports answer, whether by index, address or all
   assign target = avs_writedata[`CMD_TGT_LSB +: 16];
   assign cmd_op = cmd_op_type'(avs_writedata[`CMD_OP_LSB +: 2]);

   always_comb begin
      hit = '0;
      for (int p = 0; p < `NUM_PORTS; p++) begin
         if (avs_writedata[`CMD_ALL_BIT]) begin
            hit[p] = active_reg[p];
         end else if (target < `INDEX_LIMIT) begin
            hit[p] = active_reg[p] && (target == 16'(p));
         end else begin
            hit[p] = active_reg[p] && (target == base_reg[p]);
         end
      end
   end

   // ==========================================
   // command pulses
   // one-cycle strobes; mixing all and single commands is left to software
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sample_reg <= '0;
         update_reg <= '0;
         return_reg <= '0;
      end else if (ce) begin
         sample_reg <= '0;
         update_reg <= '0;
         return_reg <= '0;
         if (wr_go && is_cmd && avs_byteenable[0]) begin
            case (cmd_op)
               op_sample: begin
                  sample_reg <= hit;
               end
               op_update: begin
                  update_reg <= hit;
               end
               op_return: begin
                  return_reg <= hit;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================
   // port lanes
   for (genvar g = 0; g < `NUM_PORTS; g++) begin : g_lane
      lpt_lane u_lane (
         .clk_sys     (clk_sys),
         .rst_n       (rst_sync_n),
         .ce          (ce),
         .mode        (mode_reg[g]),
         .drive       (drive_reg[g]),
         .invert      (invert_reg[g]),
         .autoret     (autoret_reg[g]),
         .ret_time_ns (rettime_reg[g]),
         .do_sample   (sample_reg[g]),
         .do_update   (update_reg[g]),
         .do_return   (return_reg[g]),
         .pins_in     (pins_in[g]),
         .pins_out    (pins_out[g]),
         .pins_oe_n   (pins_oe_n[g]),
         .level_true  (level_true[g]),
         .level_not   (level_not[g]),
         .ret_pending (pending[g])
      );
   end

endmodule // lpt_gpio

//--- lpt_gpio_chk.sv
// concurrent checks on the ports of the parallel connector gpio block
`timescale 1ns/1ps
`include "lpt_gpio_map.svh"

module lpt_gpio_chk
   import lpt_gpio_pkg::*;
(
   input wire logic                    clk_sys,
   input wire logic                    rst_n,
   input wire logic                    ce,
   input wire logic [`ADDR_W-1:0]      avs_address,
   input wire logic                    avs_read,
   input wire logic                    avs_write,
   input wire logic [31:0]             avs_writedata,
   input wire logic [3:0]              avs_byteenable,
   input wire logic [31:0]             avs_readdata,
   input wire logic                    avs_waitrequest,
   input in_pins_type [`NUM_PORTS-1:0] pins_in,
   input out_pins_type [`NUM_PORTS-1:0] pins_out,
   input out_pins_type [`NUM_PORTS-1:0] pins_oe_n
);
   // ==========================================
   // bus handshake
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_start;
      (avs_read || avs_write) && !$past(avs_read || avs_write) && ce;
   endsequence
   sequence s_answer;
      avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   chk_one_wait: assert property (s_start |-> s_answer)
      else $error("waitrequest not one wait state");
   chk_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
      else $error("waitrequest low while idle");
   chk_write_zero: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("readdata not zero on write");

   // ==========================================
   // pins
   chk_reset_quiet: assert property ($rose(rst_n) |-> pins_out == '0 && pins_oe_n == '0)
      else $error("pins not deasserted after reset");
   chk_ce_freeze: assert property (!ce |=> $stable(pins_out) && $stable(pins_oe_n))
      else $error("pins moved while clock enable low");

   for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
      chk_dir_whole: assert property (pins_oe_n[p].data == 8'h00 ||
            (pins_oe_n[p].data == 8'hff && pins_out[p].data == 8'h00))
         else $error("data group direction split");
      chk_od_ctl: assert property (pins_oe_n[p].ctl != 4'h0 |-> pins_out[p].ctl == 4'h0)
         else $error("open drain control drives high");
      chk_dir_lock: assert property ($past(pins_oe_n[p].data) == 8'hff |->
            pins_oe_n[p].data == 8'hff)
         else $error("input direction changed");
   end
endmodule // lpt_gpio_chk

bind lpt_gpio lpt_gpio_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pins_in(pins_in), .pins_out(pins_out), .pins_oe_n(pins_oe_n));

//--- lpt_gpio_map.svh
// register offsets, field positions, reset values and timing for the port block
`ifndef LPT_GPIO_MAP_SVH
`define LPT_GPIO_MAP_SVH

// ==========================================
// geometry
`define NUM_PORTS      8
`define ADDR_W         9

// ==========================================
// global registers (byte addresses)
`define REG_CMD        9'h000
`define REG_STATUS     9'h004

// ==========================================
// per-port windows: address[8:5] selects window, address[4:2] the word
`define PORT_WIN_FIRST 4'h2
`define PORT_WIN_LAST  4'h9
`define OFS_CFG        3'h0
`define OFS_BASE       3'h1
`define OFS_DRIVE      3'h2
`define OFS_INVERT     3'h3
`define OFS_AUTORET    3'h4
`define OFS_RETTIME    3'h5
`define OFS_IN_TRUE    3'h6
`define OFS_IN_NOT     3'h7

// ==========================================
// fields
`define CMD_OP_LSB     0
`define CMD_ALL_BIT    2
`define CMD_TGT_LSB    16
`define CFG_MODE_LSB   0
`define CFG_ACTIVE_BIT 2
`define INDEX_LIMIT    16'h0010

// ==========================================
// reset values
`define RST_BASE       16'h0000
`define RST_RETTIME    32'h0000_0000
`define RST_PINS       12'h000

// ==========================================
// timing
`define SYS_CLK_HZ     25000000
`define NS_PER_S       1000000000
`define CYCLE_NS       (`NS_PER_S / `SYS_CLK_HZ)

`endif

//--- lpt_gpio_pkg.sv
// types shared by the port block files
package lpt_gpio_pkg;

   typedef enum logic [1:0] {mode_unset, mode_in, mode_out, mode_opendrain} port_mode_type;

   typedef enum logic [1:0] {op_none, op_sample, op_update, op_return} cmd_op_type;

   typedef struct packed {
      logic [3:0] ctl;
      logic [7:0] data;
   } out_pins_type;

   typedef struct packed {
      logic [4:0] status;
      logic [3:0] ctl;
      logic [7:0] data;
   } in_pins_type;

endpackage

//--- lpt_lane.sv
// one connector port: pin synchronisers, sampling, output latch and delayed return
`timescale 1ns/1ps
`include "lpt_gpio_map.svh"

module lpt_lane
   import lpt_gpio_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  port_mode_type      mode,
   input  out_pins_type       drive,
   input  out_pins_type       invert,
   input  out_pins_type       autoret,
   input  wire logic [31:0]   ret_time_ns,
   input  wire logic          do_sample,
   input  wire logic          do_update,
   input  wire logic          do_return,
   input  in_pins_type        pins_in,
   output out_pins_type       pins_out,
   output out_pins_type       pins_oe_n,
   output in_pins_type        level_true,
   output in_pins_type        level_not,
   output logic               ret_pending
);

   localparam logic [31:0] STEP_NS = 32'(`CYCLE_NS);

   in_pins_type  sync1_reg;
   in_pins_type  sync2_reg;
   in_pins_type  valid_mask;
   out_pins_type level_reg;
   out_pins_type level_next;
   out_pins_type ret_mask;
   logic [31:0]  elapsed_reg;
   logic         data_is_out;
   logic         open_drain;
   logic         fire;

   // ==========================================
   // direction
   assign data_is_out = (mode != mode_in);
   assign open_drain  = (mode == mode_opendrain);
   assign valid_mask  = {5'h1f, {4{open_drain}}, {8{mode == mode_in}}};
   assign ret_mask    = autoret & {4'hf, {8{data_is_out}}};

   // ==========================================
   // input synchronisers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (ce) begin
         sync1_reg <= pins_in;
         sync2_reg <= sync1_reg;
      end
   end

   // ==========================================
   // sample
   // lines that are not inputs read as zero in both views
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_true <= '0;
         level_not  <= '0;
      end else if (ce && do_sample) begin
         level_true <= sync2_reg & valid_mask;
         level_not  <= ~sync2_reg & valid_mask;
      end
   end

   // ==========================================
   // delayed return
   // saturating so a very late return still fires
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_reg <= '0;
      end else if (ce) begin
         if (do_update) begin
            elapsed_reg <= '0;
         end else if (elapsed_reg <= 32'hffff_ffff - STEP_NS) begin
            elapsed_reg <= elapsed_reg + STEP_NS;
         end
      end
   end

   assign fire = ret_pending && (elapsed_reg >= ret_time_ns);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ret_pending <= 1'b0;
      end else if (ce) begin
         if (do_return) begin
            ret_pending <= 1'b1;
         end else if (fire) begin
            ret_pending <= 1'b0;
         end
      end
   end

   // ==========================================
   // output latch
   always_comb begin
      level_next = level_reg;
      if (do_update) begin
         level_next = drive ^ invert;
      end else if (fire) begin
         level_next = (level_reg & ~ret_mask) | (invert & ret_mask);
      end
   end

   // open drain pulls low only; a high level releases the line
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_reg      <= `RST_PINS;
         pins_out       <= `RST_PINS;
         pins_oe_n.data <= 8'h00;
         pins_oe_n.ctl  <= 4'h0;
      end else if (ce) begin
         level_reg      <= level_next;
         pins_out.data  <= data_is_out ? level_next.data : 8'h00;
         pins_out.ctl   <= open_drain ? 4'h0 : level_next.ctl;
         pins_oe_n.data <= {8{!data_is_out}};
         pins_oe_n.ctl  <= open_drain ? level_next.ctl : 4'h0;
      end
   end

endmodule // lpt_lane

//--- lpt_pins_model.sv
// machine hardware on the connector pins of every port
`timescale 1ns/1ps
`include "lpt_gpio_map.svh"

module lpt_pins_model
   import lpt_gpio_pkg::*;
(
   input out_pins_type [`NUM_PORTS-1:0] pins_out,
   input out_pins_type [`NUM_PORTS-1:0] pins_oe_n,
   input wire logic [7:0]               ext_data,
   input wire logic [4:0]               ext_status,
   input wire logic [3:0]               ext_pull_low,
   output in_pins_type [`NUM_PORTS-1:0] pins_in
);
   // ==========================================
   // wire resolution, 17 lines a port
   always_comb begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
         pins_in[p].status = ext_status;
         for (int b = 0; b < 8; b++) begin
            pins_in[p].data[b] = pins_oe_n[p].data[b] ? ext_data[b] : pins_out[p].data[b];
         end
         // released control lines sit on the pull-up; gates only pull low
         for (int b = 0; b < 4; b++) begin
            pins_in[p].ctl[b] = (pins_oe_n[p].ctl[b] | pins_out[p].ctl[b]) & ~ext_pull_low[b];
         end
      end
   end
endmodule // lpt_pins_model

//--- tb_lpt_gpio.sv
// self-checking bench for the parallel connector gpio block
`timescale 1ns/1ps
`include "lpt_gpio_map.svh"

module tb_lpt_gpio
   import lpt_gpio_pkg::*;
;
   logic                      clk_sys = 1'b0;
   logic                      rst_n;
   logic                      ce;
   logic [8:0]                avs_address;
   logic                      avs_read;
   logic                      avs_write;
   logic [31:0]               avs_writedata;
   logic [3:0]                avs_byteenable;
   logic [31:0]               avs_readdata;
   logic                      avs_waitrequest;
   logic [7:0]                ext_data;
   logic [4:0]                ext_status;
   logic [3:0]                ext_pull_low;
   in_pins_type [7:0]         pins_in;
   out_pins_type [7:0]        pins_out;
   out_pins_type [7:0]        pins_oe_n;
   int                        err_total = 0;
   int                        checked = 0;

   always #20 clk_sys = ~clk_sys;

   lpt_gpio dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pins_in(pins_in), .pins_out(pins_out),
      .pins_oe_n(pins_oe_n));

   lpt_pins_model far_u (.pins_out(pins_out), .pins_oe_n(pins_oe_n), .ext_data(ext_data),
      .ext_status(ext_status), .ext_pull_low(ext_pull_low), .pins_in(pins_in));

   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      // no cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [8:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // command, then pulse and pin latency
   task automatic cmd(input logic [31:0] d);
      wr(9'h000, d);
      repeat (3) @(posedge clk_sys);
   endtask

   function automatic logic [8:0] pa(input int p, input int w);
      return 9'(9'h040 + p * 32 + w * 4);
   endfunction

   task automatic pin(input int p, input logic [11:0] exp);
      chk({20'h0, pins_out[p]}, {20'h0, exp});
   endtask

   task automatic close_out();
      $display("counts: checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ==========================================
   // watchdog
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      close_out();
   end

   // ==========================================
   // tests
   initial begin
      rst_n = 1'b0; ce = 1'b1; avs_address = 9'h0; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0; avs_byteenable = 4'hf;
      ext_data = 8'h0; ext_status = 5'h0; ext_pull_low = 4'h0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int p = 0; p < 8; p++) chk({8'h00, pins_out[p], pins_oe_n[p]}, 32'h0);
      $display("test reset done");

      wr(pa(0, 0), 32'h6);
      wr(pa(1, 0), 32'h5);
      wr(pa(2, 0), 32'h7);
      wr(pa(3, 0), 32'h4);
      rd(9'h004, 32'h0000_0f00);
      wr(pa(1, 0), 32'h6);
      rd(pa(1, 0), 32'h5);
      rd(9'h008, 32'h0);
      chk({20'h0, pins_oe_n[0]}, 32'h0);
      chk({20'h0, pins_oe_n[1]}, 32'h0ff);
      chk({20'h0, pins_oe_n[3]}, 32'h0);
      $display("test config done");

      wr(pa(0, 2), 32'ha5c);
      wr(pa(0, 3), 32'h0f0);
      wr(pa(0, 1), 32'h378);
      wr(pa(1, 2), 32'h3ff);
      wr(pa(3, 2), 32'h5c3);
      pin(0, 12'h000);
      cmd(32'h0000_0002);
      pin(0, 12'haac);
      pin(3, 12'h000);
      cmd(32'h0000_0006);
      pin(3, 12'h5c3);
      pin(1, 12'h300);
      wr(pa(0, 2), 32'h123);
      cmd(32'h0005_0002);
      pin(0, 12'haac);
      cmd(32'h0378_0002);
      pin(0, 12'h1d3);
      ce <= 1'b0;
      repeat (4) @(posedge clk_sys);
      ce <= 1'b1;
      pin(0, 12'h1d3);
      $display("test update done");

      ext_data <= 8'h3c;
      ext_status <= 5'h15;
      repeat (3) @(posedge clk_sys);
      rd(pa(1, 6), 32'h0);
      cmd(32'h0001_0001);
      rd(pa(1, 6), 32'h1503c);
      rd(pa(1, 7), 32'h0a0c3);
      rd(pa(0, 6), 32'h0);
      cmd(32'h0000_0005);
      rd(pa(0, 6), 32'h15000);
      $display("test sample done");

      // control lines shared with an external open-collector gate
      wr(pa(2, 2), 32'h500);
      ext_pull_low <= 4'h1;
      cmd(32'h0002_0002);
      chk({20'h0, pins_oe_n[2]}, 32'h500);
      pin(2, 12'h000);
      cmd(32'h0002_0001);
      rd(pa(2, 6), 32'h15400);
      $display("test open drain done");

      wr(pa(0, 4), 32'h001);
      wr(pa(0, 5), 32'd2000);
      wr(pa(0, 2), 32'h0f3);
      cmd(32'h0000_0002);
      cmd(32'h0000_0003);
      rd(9'h004, 32'h0000_0f01);
      pin(0, 12'h003);
      repeat (60) @(posedge clk_sys);
      pin(0, 12'h002);
      rd(9'h004, 32'h0000_0f00);
      $display("test return done");
      close_out();
   end
endmodule // tb_lpt_gpio
